/* File: inc/ssp_pkg.sv */
package ssp_pkg;

  // ------------------------------------------------------------
  // mode field encodings
  // ------------------------------------------------------------
  localparam logic [3:0] SSP_MODE_M_DIV4 = 4'h0;
  localparam logic [3:0] SSP_MODE_M_DIV16 = 4'h1;
  localparam logic [3:0] SSP_MODE_M_DIV64 = 4'h2;
  localparam logic [3:0] SSP_MODE_M_TMR = 4'h3;
  localparam logic [3:0] SSP_MODE_S_SEL = 4'h4;
  localparam logic [3:0] SSP_MODE_S_NOSEL = 4'h5;
  localparam logic [3:0] SSP_MODE_M_RELOAD = 4'hA;

  // ------------------------------------------------------------
  // field positions and counts
  // ------------------------------------------------------------
  localparam int SSP_CTL_MODE_LSB = 0;
  localparam int SSP_STAT_CKE_BIT = 6;
  localparam int SSP_STAT_SMP_BIT = 7;
  localparam int SSP_STAT_BF_BIT = 0;
  localparam logic [3:0] SSP_BITS = 4'h8;
  localparam logic [7:0] SSP_DIV4_HALF = 8'h02;
  localparam logic [7:0] SSP_DIV16_HALF = 8'h08;
  localparam logic [7:0] SSP_DIV64_HALF = 8'h20;
  localparam logic [7:0] SSP_BUF_RESET = 8'h00;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic polarity;
    logic [3:0] mode;
  } ssp_ctl_s;

  typedef struct packed {
    logic sample_end;
    logic edge_sel;
  } ssp_cfg_s;

  typedef struct packed {
    logic int_flag;
    logic buf_full;
    logic write_collision_flag;
  } ssp_flags_s;

  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_LEAD = 2'b01,
    SSP_TRAIL = 2'b10
  } ssp_state_e;

endpackage : ssp_pkg

/* File: hdl/ssp_port.sv */
`timescale 1ns/1ps

module ssp_port
  import ssp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire ssp_ctl_s ctl_i,
  input wire ssp_cfg_s cfg_i,
  input wire logic [7:0] reload_i,
  input wire logic timer_tick_i,
  input wire logic overwrite_en_i,
  input wire logic int_en_i,
  input wire logic wr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_i,
  input wire logic write_collision_flag_clr_i,
  input wire logic int_clr_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic ss_n_i,
  output logic sck_o,
  output logic sck_oe_o,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic [7:0] rd_data_o,
  output ssp_flags_s flags_o,
  output logic [7:0] status_o,
  output logic busy_o,
  output logic wake_o
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic is_master(input logic [3:0] m);
    is_master = (m[3:2] == 2'b00) || (m == SSP_MODE_M_RELOAD);
  endfunction : is_master

  function automatic logic is_slave(input logic [3:0] m);
    is_slave = (m[3:1] == 3'b010);
  endfunction : is_slave

  logic master;
  logic slave;
  logic sel_ctl;
  logic selected;
  logic cpha;
  assign master = ctl_i.enable && is_master(ctl_i.mode);
  assign slave = ctl_i.enable && is_slave(ctl_i.mode);
  assign sel_ctl = slave && (ctl_i.mode == SSP_MODE_S_SEL);
  assign selected = !sel_ctl || !ss_n_i;
  assign cpha = !cfg_i.edge_sel;

  ssp_state_e state;
  logic [7:0] shreg;
  logic [7:0] rxbuf;
  logic [3:0] bitcnt;
  logic [7:0] divcnt;
  logic sck_prev;
  logic samp_d;
  logic busy;
  logic write_ok;
  logic byte_done;

  // ------------------------------------------------------------
  // master rate divider
  // ------------------------------------------------------------
  logic [7:0] half_per;
  logic tick;
  always_comb begin
    case (ctl_i.mode)
      SSP_MODE_M_DIV4: half_per = SSP_DIV4_HALF;
      SSP_MODE_M_DIV16: half_per = SSP_DIV16_HALF;
      SSP_MODE_M_DIV64: half_per = SSP_DIV64_HALF;
      SSP_MODE_M_RELOAD: half_per = 8'(({1'b0, reload_i} + 9'h001) << 1);
      default: half_per = 8'h01;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      divcnt <= 8'h00;
    end else if (state == SSP_IDLE || !master) begin
      divcnt <= 8'h00;
    end else if (ctl_i.mode == SSP_MODE_M_TMR) begin
      divcnt <= 8'h00;
    end else if (divcnt + 8'h01 >= half_per) begin
      divcnt <= 8'h00;
    end else begin
      divcnt <= divcnt + 8'h01;
    end
  end

  // timer mode: every timer tick is one half period, giving timer/2
  assign tick = master && state != SSP_IDLE &&
    ((ctl_i.mode == SSP_MODE_M_TMR) ? timer_tick_i : (divcnt + 8'h01 >= half_per));

  // ------------------------------------------------------------
  // slave clock edges
  // ------------------------------------------------------------
  logic s_rise;
  logic s_fall;
  logic s_lead;
  logic s_trail;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_i;
    end
  end
  assign s_rise = sck_i && !sck_prev;
  assign s_fall = !sck_i && sck_prev;
  // leading edge leaves the idle level set by polarity
  assign s_lead = slave && selected && (ctl_i.polarity ? s_fall : s_rise);
  assign s_trail = slave && selected && (ctl_i.polarity ? s_rise : s_fall);

  // ------------------------------------------------------------
  // write acceptance
  // ------------------------------------------------------------
  assign busy = (state != SSP_IDLE) || (bitcnt != 4'h0);
  assign write_ok = wr_i && ctl_i.enable && !busy && !flags_o.write_collision_flag &&
    (overwrite_en_i || !flags_o.buf_full || master);

  // ------------------------------------------------------------
  // shift engine
  // ------------------------------------------------------------
  // per bit: a shift edge puts the next bit out, a sample edge takes sdi.
  // cpha=0 (edge bit set): data is out before the first edge, lead samples.
  logic m_lead;
  logic m_trail;
  assign m_lead = tick && state == SSP_LEAD;
  assign m_trail = tick && state == SSP_TRAIL;

  logic samp;
  logic shft;
  always_comb begin
    samp = 1'b0;
    shft = 1'b0;
    if (master) begin
      samp = cpha ? m_trail : m_lead;
      shft = cpha ? m_lead : m_trail;
    end else if (slave) begin
      samp = cpha ? s_trail : s_lead;
      shft = cpha ? s_lead : s_trail;
    end
  end

  logic sdi_use;
  logic take;
  // sample-at-end takes the input one clock after the sampling edge,
  // still ahead of the far side moving on at the next shift edge
  assign sdi_use = sdi_i;
  assign take = (master && cfg_i.sample_end) ? samp_d : samp;
  assign byte_done = take && (bitcnt == SSP_BITS - 4'h1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      samp_d <= 1'b0;
    end else begin
      samp_d <= samp && master && cfg_i.sample_end;
    end
  end

  logic out_bit;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg <= SSP_BUF_RESET;
      bitcnt <= 4'h0;
      out_bit <= 1'b0;
    end else if (!ctl_i.enable) begin
      bitcnt <= 4'h0;
    end else if (write_ok) begin
      shreg <= wr_data_i;
      out_bit <= wr_data_i[7];
    end else if (sel_ctl && ss_n_i) begin
      bitcnt <= 4'h0;
    end else begin
      // the shift edge after a full byte puts the received msb out again
      if (shft) begin
        out_bit <= shreg[7];
      end
      if (take) begin
        shreg <= {shreg[6:0], sdi_use};
        bitcnt <= byte_done ? 4'h0 : bitcnt + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // master sequencer and serial clock
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SSP_IDLE;
      sck_o <= 1'b0;
    end else if (!master) begin
      state <= SSP_IDLE;
      sck_o <= ctl_i.polarity;
    end else begin
      case (state)
        SSP_IDLE: begin
          sck_o <= ctl_i.polarity;
          if (write_ok) begin
            state <= SSP_LEAD;
          end
        end
        SSP_LEAD: begin
          if (tick) begin
            sck_o <= !ctl_i.polarity;
            state <= SSP_TRAIL;
          end
        end
        SSP_TRAIL: begin
          if (tick) begin
            sck_o <= ctl_i.polarity;
            // both settings end on the eighth trail: trailing-edge sampling at bitcnt 7, leading-edge sampling once bitcnt has wrapped to 0
            state <= (cpha ? (bitcnt == SSP_BITS - 4'h1) : (bitcnt == 4'h0)) ?
              SSP_IDLE : SSP_LEAD;
          end
        end
        default: state <= SSP_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_oe_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      sdo_o <= 1'b0;
    end else begin
      sck_oe_o <= master;
      sdo_oe_o <= master || (slave && selected);
      sdo_o <= (cpha && bitcnt == 4'h0 && !busy) ? shreg[7] : out_bit;
    end
  end

  // ------------------------------------------------------------
  // receive buffer and flags
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxbuf <= SSP_BUF_RESET;
    end else if (byte_done) begin
      rxbuf <= {shreg[6:0], sdi_use};
    end else if (write_ok) begin
      rxbuf <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= '0;
    end else begin
      if (byte_done) begin
        flags_o.buf_full <= 1'b1;
      end else if (rd_i) begin
        flags_o.buf_full <= 1'b0;
      end
      if (byte_done) begin
        flags_o.int_flag <= 1'b1;
      end else if (int_clr_i) begin
        flags_o.int_flag <= 1'b0;
      end
      if (wr_i && ctl_i.enable && busy) begin
        flags_o.write_collision_flag <= 1'b1;
      end else if (write_collision_flag_clr_i) begin
        flags_o.write_collision_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= SSP_BUF_RESET;
      status_o <= 8'h00;
      busy_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      rd_data_o <= byte_done ? {shreg[6:0], sdi_use} : rxbuf;
      status_o <= {cfg_i.sample_end, cfg_i.edge_sel, 5'h00, flags_o.buf_full};
      busy_o <= busy;
      wake_o <= slave && int_en_i && (flags_o.int_flag || byte_done);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_done_flags;
    @(posedge clk_i) disable iff (!rst_n_i)
    byte_done |=> flags_o.buf_full && flags_o.int_flag;
  endproperty
  a_done_flags: assert property (p_done_flags) else $error("byte end did not set flags");

  property p_write_collision_flag;
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && ctl_i.enable && busy) |=> flags_o.write_collision_flag;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

  property p_write_collision_flag_block;
    @(posedge clk_i) disable iff (!rst_n_i)
    (flags_o.write_collision_flag && wr_i && !byte_done) |=> $stable(rxbuf);
  endproperty
  a_write_collision_flag_block: assert property (p_write_collision_flag_block) else $error("write taken under collision");

  property p_read_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && !byte_done) |=> !flags_o.buf_full;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read left full flag");

  property p_disable_pins;
    @(posedge clk_i) disable iff (!rst_n_i)
    !ctl_i.enable |=> !sck_oe_o && !sdo_oe_o;
  endproperty
  a_disable_pins: assert property (p_disable_pins) else $error("pins driven while off");

  property p_start;
    @(posedge clk_i) disable iff (!rst_n_i)
    (master && write_ok) |=> state == SSP_LEAD;
  endproperty
  a_start: assert property (p_start) else $error("master did not start");

  property p_idle_level;
    @(posedge clk_i) disable iff (!rst_n_i)
    (master && state == SSP_IDLE) ##1 (state == SSP_IDLE) |-> sck_o == $past(ctl_i.polarity);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock idle level wrong");

  property p_desel;
    @(posedge clk_i) disable iff (!rst_n_i)
    (sel_ctl && ss_n_i) |=> !sdo_oe_o && bitcnt == 4'h0;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect not honoured");

  property p_load;
    @(posedge clk_i) disable iff (!rst_n_i)
    write_ok |=> shreg == $past(wr_data_i) && rxbuf == $past(wr_data_i);
  endproperty
  a_load: assert property (p_load) else $error("write did not load both");

endmodule : ssp_port

/* File: verification/ssp_slave_model.sv */
`timescale 1ns/1ps

// ------------------------------
// external slave for master role
// ------------------------------
module ssp_slave_model (
  input wire logic sck_i,
  input wire logic sel_n_i,
  input wire logic cap_rise_i,
  input wire logic data_i,
  input wire logic [7:0] tx_i,
  output logic data_o,
  output logic [7:0] rx_o
);
  logic [3:0] cnt = 4'h0;

  initial begin
    data_o = 1'b0;
    rx_o = 8'h00;
  end

  // released line shows an inverted, meaningless level
  always @(sel_n_i) begin
    if (!sel_n_i) begin
      cnt = 4'h0;
      data_o = tx_i[7];
    end else begin
      data_o = ~data_o;
    end
  end

  always @(sck_i) begin
    if (!sel_n_i && sck_i === cap_rise_i) begin
      rx_o = {rx_o[6:0], data_i};
      cnt = cnt + 4'h1;
    end else if (!sel_n_i && cnt < 4'h8) begin
      data_o = tx_i[3'h7 - cnt[2:0]];
    end
  end
endmodule : ssp_slave_model

/* File: verification/ssp_port_tb.sv */
`timescale 1ns/1ps

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module ssp_port_tb;
  import ssp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  ssp_ctl_s ctl_i = '0;
  ssp_cfg_s cfg_i = '0;
  logic [7:0] reload_i = 8'h00;
  logic timer_tick_i = 1'b0;
  logic [1:0] tk = 2'h0;
  logic overwrite_en_i = 1'b0;
  logic int_en_i = 1'b0;
  logic wr_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00;
  logic rd_i = 1'b0;
  logic write_collision_flag_clr_i = 1'b0;
  logic int_clr_i = 1'b0;
  logic sck_i = 1'b0;
  logic tb_sdi = 1'b0;
  logic ss_n_i = 1'b1;
  logic slave_mode = 1'b0;
  logic p_sel_n = 1'b1;
  logic sck_o, sck_oe_o, sdo_o, sdo_oe_o, busy_o, wake_o, p_sdo;
  logic [7:0] rd_data_o, status_o, p_rx, got, a, b;
  logic [7:0] p_tx = 8'h00;
  logic [7:0] e;
  logic [7:0] q[$];
  logic [3:0] mtab[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA};
  ssp_flags_s flags_o;
  wire sdi_w = slave_mode ? tb_sdi : p_sdo;
  int err_total = 0;
  int comparisons = 0;
  int seed = 32'h4cfe;
  int half = 2;
  int n;

  always #20 clk_i = ~clk_i;

  // one timer pulse every third cycle
  always @(posedge clk_i) begin
    tk <= (tk == 2'h2) ? 2'h0 : tk + 2'h1;
    timer_tick_i <= (tk == 2'h2);
  end

  ssp_port dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ctl_i(ctl_i), .cfg_i(cfg_i),
    .reload_i(reload_i), .timer_tick_i(timer_tick_i), .overwrite_en_i(overwrite_en_i),
    .int_en_i(int_en_i), .wr_i(wr_i), .wr_data_i(wr_data_i), .rd_i(rd_i),
    .write_collision_flag_clr_i(write_collision_flag_clr_i), .int_clr_i(int_clr_i), .sck_i(sck_i), .sdi_i(sdi_w),
    .ss_n_i(ss_n_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .rd_data_o(rd_data_o), .flags_o(flags_o), .status_o(status_o),
    .busy_o(busy_o), .wake_o(wake_o));

  ssp_slave_model part_u (.sck_i(sck_o), .sel_n_i(p_sel_n),
    .cap_rise_i(ctl_i.polarity ^ cfg_i.edge_sel), .data_i(sdo_o), .tx_i(p_tx),
    .data_o(p_sdo), .rx_o(p_rx));

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask : tick

  task automatic wr_byte(input logic [7:0] d);
    wr_data_i <= d;
    wr_i <= 1'b1;
    tick(1);
    wr_i <= 1'b0;
    tick(1);
  endtask : wr_byte

  task automatic ack();
    rd_i <= 1'b1;
    int_clr_i <= 1'b1;
    tick(1);
    rd_i <= 1'b0;
    int_clr_i <= 1'b0;
    tick(2);
  endtask : ack

  task automatic setup(input logic [3:0] m, input logic pol, input logic cke);
    ctl_i.enable <= 1'b0;
    tick(3);
    `CHK({sck_oe_o, sdo_oe_o}, 2'b00)
    ctl_i <= '{1'b0, pol, m};
    cfg_i <= '{m[2] ? 1'b0 : 1'($random(seed)), cke};
    sck_i <= pol;
    slave_mode <= m[2];
    overwrite_en_i <= 1'b0;
    write_collision_flag_clr_i <= 1'b1;
    case (m)
      4'h0: half = 2;
      4'h1: half = 8;
      4'h2: half = 32;
      4'h3: half = 3;
      default: half = 2 * (int'(reload_i) + 1);
    endcase
    tick(1);
    write_collision_flag_clr_i <= 1'b0;
    ctl_i.enable <= 1'b1;
    ack();
  endtask : setup

  task automatic m_xfer(input logic [7:0] d, input logic col);
    a = 8'($random(seed));
    p_tx <= a;
    q.push_back(a);
    tick(1);
    p_sel_n <= 1'b0;
    tick(1);
    wr_data_i <= d;
    wr_i <= 1'b1;
    tick(1);
    wr_data_i <= ~d;
    n = 1;
    while (flags_o.int_flag !== 1'b1 && n < 5000) begin
      wr_i <= (col && n == 4);
      tick(1);
      n++;
    end
    wr_i <= 1'b0;
    `CHK((n >= 14 * half) && (n <= 17 * half + 6), 1'b1)
    e = q.pop_front();
    `CHK(rd_data_o, e)
    `CHK(p_rx, d)
    `CHK(flags_o.write_collision_flag, col)
    while (busy_o !== 1'b0 && n < 5000) begin
      tick(1);
      n++;
    end
    `CHK(sck_o, ctl_i.polarity)
    `CHK(status_o, {cfg_i, 6'h01})
    p_sel_n <= 1'b1;
    ack();
    `CHK(flags_o.buf_full, 1'b0)
  endtask : m_xfer

  task automatic s_xfer(input logic [7:0] d, input int nb, input logic sel);
    ss_n_i <= ~sel;
    tb_sdi <= d[7];
    tick(6);
    for (int i = 0; i < nb; i++) begin
      if (cfg_i.edge_sel) got = {got[6:0], sdo_o};
      else tb_sdi <= d[7 - i];
      sck_i <= ~ctl_i.polarity;
      tick(6);
      if (!cfg_i.edge_sel) got = {got[6:0], sdo_o};
      else if (i < 7) tb_sdi <= d[6 - i];
      sck_i <= ctl_i.polarity;
      tick(6);
    end
    if (nb == 8 && sel) begin
      q.push_back(d);
      n = 0;
      while (flags_o.int_flag !== 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      tick(2);
      e = q.pop_front();
      `CHK(rd_data_o, e)
      `CHK(wake_o, int_en_i)
    end
    ss_n_i <= 1'b1;
    tb_sdi <= ~tb_sdi;
    tick(3);
  endtask : s_xfer

  task automatic wrap_up();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  initial begin
    tick(20000);
    err_total++;
    wrap_up();
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    tick(5);
    rst_n_i <= 1'b1;
    tick(1);
    for (int i = 0; i < 20; i++) begin
      reload_i <= {6'h00, 2'($random(seed))};
      tick(1);
      setup(mtab[i % 5], i[0], i[1]);
      m_xfer(8'($random(seed)), i == 7);
      if (i == 7) begin
        wr_byte(8'h3C);
        tick(2);
        `CHK(busy_o, 1'b0)
      end
    end
    for (int i = 0; i < 4; i++) begin
      int_en_i <= i[0];
      setup(i[1] ? SSP_MODE_S_NOSEL : SSP_MODE_S_SEL, i[0], ~i[1]);
      a = 8'($random(seed));
      b = 8'($random(seed));
      wr_byte(a);
      s_xfer(b, 8, 1'b1);
      `CHK(got, a)
      ack();
      s_xfer(~a, 8, 1'b1);
      `CHK(got, b)
      overwrite_en_i <= 1'b1;
      wr_byte(a);
      s_xfer(b, 8, 1'b1);
      `CHK(got, a)
      ack();
    end
    setup(SSP_MODE_S_SEL, 1'b0, 1'b1);
    s_xfer(8'hA5, 4, 1'b1);
    `CHK(sdo_oe_o, 1'b0)
    s_xfer(8'h5A, 8, 1'b0);
    `CHK({flags_o.int_flag, sdo_oe_o}, 2'b00)
    s_xfer(8'hC3, 8, 1'b1);
    wrap_up();
  end
endmodule : ssp_port_tb
